// *** rtl/psr_defs.vh ***
// Constants for the refresh and power-state block
`ifndef PSR_DEFS_VH
`define PSR_DEFS_VH
// Register byte addresses
`define PSR_ADDR_PRIMARY     8'h00
`define PSR_ADDR_REFRESH     8'h04
`define PSR_ADDR_STATUS      8'h08
`define PSR_ADDR_LINK        8'h0C
// Field positions and reset values
`define PSR_SLEEP_BIT        15
`define PSR_PRIMARY_RESET    16'h8000
`define PSR_REFRESH_RESET    16'h0002
// Interval codes
`define PSR_RI_X2            2'h0
`define PSR_RI_X4            2'h1
`define PSR_RI_X1            2'h2
`define PSR_RI_X1P5          2'h3
// Timing in ns (entry and exit in us) at 25 MHz (40 ns)
`define PSR_CLK_NS           40
`define PSR_ENTRY_US         10
`define PSR_EXIT_US          150
`define PSR_WAKE_NS          200
`define PSR_ROW_IND_NS       4000
`define PSR_ROW_EXT_NS       1000
`define PSR_ROWS             8192
`define PSR_REFRESH_CYC      3'h4
// AXI responses
`define PSR_RESP_OKAY        2'h0
`define PSR_RESP_SLVERR      2'h2
`endif

// *** rtl/psr_refresh_power.v ***
// Refresh scheduler, deep sleep control and strobe line driving
//
// The implementer's own choices: the AXI4-Lite slave port and the register addresses.
`include "psr_defs.vh"
module psr_refresh_power #(
  parameter        DUAL_DIE   = 0,
  parameter        EXT_TEMP   = 0,
  parameter [31:0] ENTRY_CYC  = (`PSR_ENTRY_US * 1000 + `PSR_CLK_NS - 1) / `PSR_CLK_NS,
  parameter [31:0] EXIT_CYC   = (`PSR_EXIT_US * 1000) / `PSR_CLK_NS,
  parameter [31:0] ROW_CYC    = (EXT_TEMP ? `PSR_ROW_EXT_NS : `PSR_ROW_IND_NS) / `PSR_CLK_NS
) (
  // Clock and reset
  input  wire        sys_clk_i,
  input  wire        reset_n_i,
  // AXI4-Lite write address and data
  input  wire [7:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  // AXI4-Lite write response
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  // AXI4-Lite read
  input  wire [7:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  // Memory link pins
  input  wire        chip_select_n_i,
  input  wire        link_clk_i,
  input  wire        hw_reset_n_i,
  // Strobe mask line and data lines
  input  wire        strobe_mask_line_i,
  output reg         strobe_mask_line_o,
  output reg         strobe_mask_line_oe_o,
  output wire [7:0]  data_lines_o,
  output reg         data_lines_oe_o,
  // Phase from the transaction engine
  input  wire        access_is_read_i,
  input  wire        access_zero_lat_i,
  // State
  output wire        deep_sleep_state_o,
  output reg         array_valid_o,
  output reg         refresh_pulse_o
);
  localparam [31:0] WAKE_CYC = (`PSR_WAKE_NS + `PSR_CLK_NS - 1) / `PSR_CLK_NS;
  localparam [4:0] ST_STANDBY = 5'h01;
  localparam [4:0] ST_ENTER   = 5'h02;
  localparam [4:0] ST_SLEEP   = 5'h04;
  localparam [4:0] ST_EXIT    = 5'h08;
  localparam [4:0] ST_POR     = 5'h10;
  localparam [3:0] PH_IDLE = 4'h1;
  localparam [3:0] PH_CA   = 4'h2;
  localparam [3:0] PH_LAT  = 4'h4;
  localparam [3:0] PH_DATA = 4'h8;
  localparam [2:0] CA_EDGES = 3'h6;

  // Reset release
  reg rst_m;
  reg rst_n;
  always @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rst_m <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_m <= 1'b1;
      rst_n <= rst_m;
    end
  end

  // Pin synchronisers
  wire [2:0] pins_s;
  // Link clock idles low, so no false edge after reset
  psr_sync #(.WIDTH(3), .INIT(3'h5)) u_sync (
    .clk_i   (sys_clk_i),
    .rst_n_i (rst_n),
    .d_i     ({chip_select_n_i, link_clk_i, hw_reset_n_i}),
    .q_o     (pins_s)
  );
  wire cs_n_s  = pins_s[2];
  wire lclk_s  = pins_s[1];
  wire hwrst_s = ~pins_s[0];
  reg  cs_n_d;
  reg  lclk_d;
  wire cs_fall = cs_n_d & ~cs_n_s;
  wire cs_rise = ~cs_n_d & cs_n_s;
  wire lclk_edge = lclk_d ^ lclk_s;

  // Registers
  reg  [15:0] primary_config_reg;
  reg  [15:0] refresh_config_reg;
  reg  [4:0]  state;
  reg  [31:0] timer;
  reg  [31:0] cs_low_cnt;
  reg         wake_armed;
  wire        sleeping = (state == ST_SLEEP);
  assign deep_sleep_state_o = sleeping;

  // AXI write: address and data in either order
  reg        aw_held;
  reg        w_held;
  reg [7:0]  aw_addr;
  reg [31:0] w_data;
  reg [3:0]  w_strb;
  assign s_axi_awready = ~aw_held & ~s_axi_bvalid;
  assign s_axi_wready  = ~w_held & ~s_axi_bvalid;
  wire aw_now = aw_held | s_axi_awvalid;
  wire w_now  = w_held | s_axi_wvalid;
  wire [7:0]  wr_addr = aw_held ? aw_addr : s_axi_awaddr;
  wire [31:0] wr_data = w_held ? w_data : s_axi_wdata;
  wire [3:0]  wr_strb = w_held ? w_strb : s_axi_wstrb;
  wire do_write = aw_now & w_now & ~s_axi_bvalid;

  function [15:0] merge16;
    input [15:0] old;
    input [31:0] data;
    input [3:0]  strb;
    begin
      merge16 = {strb[1] ? data[15:8] : old[15:8], strb[0] ? data[7:0] : old[7:0]};
    end
  endfunction

  function is_mapped;
    input [7:0] addr;
    begin
      is_mapped = (addr == `PSR_ADDR_PRIMARY) | (addr == `PSR_ADDR_REFRESH) |
                  (addr == `PSR_ADDR_STATUS) | (addr == `PSR_ADDR_LINK);
    end
  endfunction

  wire wr_primary = do_write & (wr_addr == `PSR_ADDR_PRIMARY);
  wire wr_refresh = do_write & (wr_addr == `PSR_ADDR_REFRESH);
  wire [15:0] next_primary = merge16(primary_config_reg, wr_data, wr_strb);
  wire sleep_req = wr_primary & ~next_primary[`PSR_SLEEP_BIT] & (DUAL_DIE == 0);

  always @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `PSR_RESP_OKAY;
    end else begin
      if (do_write) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= is_mapped(wr_addr) ? `PSR_RESP_OKAY : `PSR_RESP_SLVERR;
      end else begin
        if (s_axi_awvalid & s_axi_awready) begin
          aw_held <= 1'b1;
          aw_addr <= s_axi_awaddr;
        end
        if (s_axi_wvalid & s_axi_wready) begin
          w_held <= 1'b1;
          w_data <= s_axi_wdata;
          w_strb <= s_axi_wstrb;
        end
        if (s_axi_bready) s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Configuration registers, reset to power-on values on wake
  always @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      primary_config_reg <= `PSR_PRIMARY_RESET;
      refresh_config_reg <= `PSR_REFRESH_RESET;
    end else if (hwrst_s | (state == ST_EXIT)) begin
      primary_config_reg <= `PSR_PRIMARY_RESET;
      refresh_config_reg <= `PSR_REFRESH_RESET;
    end else begin
      if (wr_primary)
        primary_config_reg <= (DUAL_DIE != 0) ? (next_primary | `PSR_PRIMARY_RESET) : next_primary;
      if (wr_refresh)
        refresh_config_reg <= merge16(refresh_config_reg, wr_data, wr_strb);
    end
  end

  // AXI read
  reg  [31:0] rd_mux;
  always @* begin
    case (s_axi_araddr)
      `PSR_ADDR_PRIMARY: rd_mux = {16'h0000, primary_config_reg};
      `PSR_ADDR_REFRESH: rd_mux = {16'h0000, refresh_config_reg};
      `PSR_ADDR_STATUS:  rd_mux = {27'h0000000, state};
      `PSR_ADDR_LINK:    rd_mux = {29'h00000000, array_valid_o, cs_n_s, sleeping};
      default:           rd_mux = 32'h0000_0000;
    endcase
  end
  assign s_axi_arready = ~s_axi_rvalid;
  always @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `PSR_RESP_OKAY;
    end else if (s_axi_arvalid & s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_mux;
      s_axi_rresp <= is_mapped(s_axi_araddr) ? `PSR_RESP_OKAY : `PSR_RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // Power state machine
  always @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      state <= ST_POR;
      timer <= 32'h0000_0000;
      cs_low_cnt <= 32'h0000_0000;
      wake_armed <= 1'b0;
      cs_n_d <= 1'b1;
      lclk_d <= 1'b0;
      array_valid_o <= 1'b1;
    end else begin
      cs_n_d <= cs_n_s;
      lclk_d <= lclk_s;
      case (state)
        ST_POR: begin
          state <= ST_STANDBY;
        end
        ST_STANDBY: begin
          if (sleep_req) begin
            state <= ST_ENTER;
            timer <= ENTRY_CYC;
          end
        end
        ST_ENTER: begin
          if (timer <= 32'h0000_0001) begin
            state <= ST_SLEEP;
            array_valid_o <= 1'b0;
          end else begin
            timer <= timer - 32'h0000_0001;
          end
        end
        ST_SLEEP: begin
          // Only select and reset are watched here
          if (~cs_n_s)
            cs_low_cnt <= cs_low_cnt + 32'h0000_0001;
          else
            cs_low_cnt <= 32'h0000_0000;
          if (cs_fall)
            wake_armed <= 1'b1;
          if (hwrst_s | (cs_rise & wake_armed & (cs_low_cnt >= WAKE_CYC))) begin
            state <= ST_EXIT;
            timer <= EXIT_CYC;
            wake_armed <= 1'b0;
          end
        end
        ST_EXIT: begin
          // Wake transaction is ignored
          if (timer <= 32'h0000_0001)
            state <= ST_STANDBY;
          else
            timer <= timer - 32'h0000_0001;
        end
        default: state <= ST_POR;
      endcase
    end
  end

  // Distributed refresh tick from interval field
  function [31:0] row_period;
    input [1:0] code;
    begin
      case (code)
        `PSR_RI_X1:   row_period = ROW_CYC;
        `PSR_RI_X1P5: row_period = ROW_CYC + (ROW_CYC >> 1);
        `PSR_RI_X2:   row_period = ROW_CYC << 1;
        `PSR_RI_X4:   row_period = ROW_CYC << 2;
        default:      row_period = ROW_CYC;
      endcase
    end
  endfunction

  reg  [31:0] tick_cnt;
  reg  [12:0] row_addr;
  reg         refresh_pend;
  reg  [2:0]  refresh_busy;
  wire        host_active = ~cs_n_s;
  wire        tick = (tick_cnt == 32'h0000_0000);
  wire        running = (state == ST_STANDBY);

  always @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      tick_cnt <= 32'h0000_0000;
      row_addr <= 13'h0000;
      refresh_pend <= 1'b0;
      refresh_busy <= 3'h0;
      refresh_pulse_o <= 1'b0;
    end else begin
      refresh_pulse_o <= 1'b0;
      if (!running) begin
        tick_cnt <= row_period(refresh_config_reg[1:0]) - 32'h0000_0001;
        refresh_pend <= 1'b0;
        refresh_busy <= 3'h0;
      end else begin
        // One row per tick, spread evenly
        if (tick)
          tick_cnt <= row_period(refresh_config_reg[1:0]) - 32'h0000_0001;
        else
          tick_cnt <= tick_cnt - 32'h0000_0001;
        if (refresh_busy != 3'h0)
          refresh_busy <= refresh_busy - 3'h1;
        // A tick landing while busy or selected stays pending; one tick is held, a further tick is lost
        if ((refresh_busy == 3'h0) & (refresh_pend | tick) & ~host_active) begin
          refresh_busy <= `PSR_REFRESH_CYC;
          refresh_pulse_o <= 1'b1;
          row_addr <= row_addr + 13'h0001;
          refresh_pend <= refresh_pend & tick;
        end else if (tick) begin
          refresh_pend <= 1'b1;
        end
      end
    end
  end

  // Link phase tracker, clocked by sys_clk_i, counting sampled link clock edges
  reg [3:0] phase;
  reg [2:0] ca_cnt;
  reg       long_lat;
  wire      dev_reset = ~rst_n | hwrst_s;
  always @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      phase <= PH_IDLE;
      ca_cnt <= 3'h0;
      long_lat <= 1'b0;
    end else if (cs_n_s | hwrst_s | ~running) begin
      phase <= PH_IDLE;
      ca_cnt <= 3'h0;
    end else begin
      case (phase)
        PH_IDLE: begin
          phase <= PH_CA;
          long_lat <= refresh_pend | (refresh_busy != 3'h0) | primary_config_reg[3];
        end
        PH_CA: begin
          if (lclk_edge) ca_cnt <= ca_cnt + 3'h1;
          if (lclk_edge & (ca_cnt == CA_EDGES - 3'h1))
            // Zero-latency data phase samples no mask
            phase <= access_zero_lat_i ? PH_DATA : PH_LAT;
        end
        PH_LAT: phase <= PH_LAT;
        PH_DATA: phase <= PH_DATA;
        default: phase <= PH_IDLE;
      endcase
    end
  end

  // Strobe and data drive
  assign data_lines_o = 8'h00;
  always @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      strobe_mask_line_o <= 1'b0;
      strobe_mask_line_oe_o <= 1'b0;
      data_lines_oe_o <= 1'b0;
    end else begin
      strobe_mask_line_o <= 1'b0;
      strobe_mask_line_oe_o <= 1'b0;
      data_lines_oe_o <= 1'b0;
      if (!(dev_reset | cs_n_s | sleeping)) begin
        if (phase == PH_CA) begin
          strobe_mask_line_oe_o <= 1'b1;
          strobe_mask_line_o <= long_lat;
        end else if ((phase == PH_LAT) & access_is_read_i) begin
          strobe_mask_line_oe_o <= 1'b1;
        end
      end
    end
  end
endmodule // psr_refresh_power

// *** rtl/psr_sync.v ***
// Two flip-flop synchroniser for pin inputs
module psr_sync #(
  parameter WIDTH = 1,
  parameter [WIDTH-1:0] INIT = {WIDTH{1'b0}}
) (
  // Clock and reset
  input  wire             clk_i,
  input  wire             rst_n_i,
  // Data
  input  wire [WIDTH-1:0] d_i,
  output wire [WIDTH-1:0] q_o
);
  reg [WIDTH-1:0] meta;
  reg [WIDTH-1:0] sync;
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta <= INIT;
      sync <= INIT;
    end else begin
      meta <= d_i;
      sync <= meta;
    end
  end
  assign q_o = sync;
endmodule // psr_sync

// *** test/psr_host_model.sv ***
// Host controller model: select, link clock, strobe wire
module psr_host_model (
  // Clock
  input  wire logic sys_clk_i,
  // Device strobe drive
  input  wire logic dev_strobe_i,
  input  wire logic dev_strobe_oe_i,
  // Link pins
  output logic      chip_select_n_o,
  output logic      link_clk_o,
  output logic      strobe_wire_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial chip_select_n_o = 1'h1;
  initial link_clk_o = 1'h0;
  // Released line shows the inverse, as the host's mask level
  assign strobe_wire_o = dev_strobe_oe_i ? dev_strobe_i : ~dev_strobe_i;
  // Frame of n link clocks, 6 + 8n cycles low (70 for n = 8); clock parked low between
  // Frames stay short, so the host never takes over refresh
  task automatic frame(input int n);
    repeat (3) @(posedge sys_clk_i);
    chip_select_n_o <= 1'h0;
    repeat (6) @(posedge sys_clk_i);
    for (int i = 0; i < n; i++) begin
      repeat (4) @(posedge sys_clk_i);
      link_clk_o <= 1'h1;
      repeat (4) @(posedge sys_clk_i);
      link_clk_o <= 1'h0;
    end
    chip_select_n_o <= 1'h1;
  endtask
endmodule // psr_host_model

// *** test/psr_refresh_power_checker.sv ***
// Port assertions for the refresh and power-state block
module psr_refresh_power_checker (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic reset_n_i,
  // Link pins
  input wire logic chip_select_n_i,
  input wire logic strobe_mask_line_o,
  input wire logic strobe_mask_line_oe_o,
  input wire logic data_lines_oe_o,
  // State
  input wire logic deep_sleep_state_o,
  input wire logic array_valid_o,
  input wire logic refresh_pulse_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!reset_n_i);
  sequence s_deselected; chip_select_n_i [*5]; endsequence
  sequence s_selected; !chip_select_n_i [*5]; endsequence
  sequence s_asleep; deep_sleep_state_o [*2]; endsequence
  a_idle_released: assert property (s_deselected |-> !strobe_mask_line_oe_o)
    else $error("strobe driven while deselected");
  a_data_quiet: assert property (!data_lines_oe_o)
    else $error("data lines driven");
  a_pulse_spaced: assert property (refresh_pulse_o |=> !refresh_pulse_o [*3])
    else $error("refresh pulses too close");
  a_defer_select: assert property (s_selected |-> !refresh_pulse_o)
    else $error("refresh while selected");
  a_sleep_quiet: assert property (s_asleep |-> !refresh_pulse_o && !strobe_mask_line_oe_o)
    else $error("activity in deep sleep");
  a_array_lost: assert property (s_asleep |-> !array_valid_o)
    else $error("array valid in deep sleep");
  a_array_stays: assert property ($fell(array_valid_o) |=> !array_valid_o [*8])
    else $error("array valid returned");
  a_drive_selected: assert property ($rose(strobe_mask_line_oe_o) |-> !chip_select_n_i)
    else $error("strobe driven without select");
endmodule // psr_refresh_power_checker

// *** test/psr_refresh_power_tb.sv ***
// Self-checking bench for the refresh and power-state block
`include "psr_defs.vh"
module psr_refresh_power_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int ENTRY = 5;
  localparam int ROW   = 20;
  logic        sys_clk_i = 1'h0, reset_n_i = 1'h0, hw_reset_n_i = 1'h1;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic        s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic        access_is_read_i = 1'h0, access_zero_lat_i = 1'h0;
  wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire         chip_select_n_i, link_clk_i, strobe_mask_line_i, strobe_mask_line_o;
  wire         strobe_mask_line_oe_o, data_lines_oe_o, deep_sleep_state_o;
  wire         array_valid_o, refresh_pulse_o;
  wire [1:0]   s_axi_bresp, s_axi_rresp;
  wire [31:0]  s_axi_rdata;
  int          miscompares = 0, total_checks = 0;
  always #20 sys_clk_i = ~sys_clk_i;
  psr_refresh_power #(.ENTRY_CYC(ENTRY), .EXIT_CYC(10), .ROW_CYC(ROW)) dut_u (
    .sys_clk_i, .reset_n_i, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .chip_select_n_i,
    .link_clk_i, .hw_reset_n_i, .strobe_mask_line_i, .strobe_mask_line_o,
    .strobe_mask_line_oe_o, .data_lines_o(), .data_lines_oe_o, .access_is_read_i,
    .access_zero_lat_i, .deep_sleep_state_o, .array_valid_o, .refresh_pulse_o);
  psr_host_model host_u (.sys_clk_i, .dev_strobe_i(strobe_mask_line_o),
    .dev_strobe_oe_i(strobe_mask_line_oe_o), .chip_select_n_o(chip_select_n_i),
    .link_clk_o(link_clk_i), .strobe_wire_o(strobe_mask_line_i));
  task automatic results();
    $display("checks %0d miscompares %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic stall();
    miscompares++;
    results();
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    @(posedge sys_clk_i);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid  <= 1'h1;
    s_axi_bready  <= 1'h1;
    do begin
      @(posedge sys_clk_i);
      n++;
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
    end while (s_axi_bvalid !== 1'h1 && n < 50);
    r = s_axi_bresp;
    s_axi_bready <= 1'h0;
    if (n >= 50) stall();
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    @(posedge sys_clk_i);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready  <= 1'h1;
    do begin
      @(posedge sys_clk_i);
      n++;
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
    end while (s_axi_rvalid !== 1'h1 && n < 50);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'h0;
    if (n >= 50) stall();
  endtask
  task automatic gap(output int c);
    c = 0;
    do begin
      @(posedge sys_clk_i);
      c++;
    end while (refresh_pulse_o !== 1'h1 && c < 200);
    if (c >= 200) stall();
  endtask
  task automatic probe(input int n, input logic [1:0] e);
    repeat (n) @(posedge sys_clk_i);
    chk({30'h0, strobe_mask_line_oe_o, strobe_mask_line_oe_o & strobe_mask_line_o}, {30'h0, e});
  endtask
  task automatic sc_reset();
    logic [31:0] d;
    logic [1:0]  r;
    rd(`PSR_ADDR_PRIMARY, d, r);
    chk(d, 32'h8000);
    rd(`PSR_ADDR_REFRESH, d, r);
    chk(d, 32'h2);
    rd(`PSR_ADDR_LINK, d, r);
    chk(d, 32'h6);
    rd(8'h10, d, r);
    chk({30'h0, r}, {30'h0, `PSR_RESP_SLVERR});
    wr(8'h10, 32'h1, r);
    chk({30'h0, r}, {30'h0, `PSR_RESP_SLVERR});
    s_axi_wstrb <= 4'h1;
    wr(`PSR_ADDR_REFRESH, 32'h0000_FF03, r);
    s_axi_wstrb <= 4'hF;
    rd(`PSR_ADDR_REFRESH, d, r);
    chk(d, 32'h3);
  endtask
  task automatic sc_period();
    int          m[4] = '{4, 8, 2, 3};
    int          c;
    logic [31:0] d;
    logic [1:0]  r;
    for (int k = 0; k < 4; k++) begin
      wr(`PSR_ADDR_REFRESH, 32'(k), r);
      rd(`PSR_ADDR_REFRESH, d, r);
      chk(d, 32'(k));
      gap(c);
      gap(c);
      gap(c);
      chk(32'(c), 32'(ROW * m[k] / 2));
    end
  endtask
  task automatic sc_link();
    logic [1:0] r;
    wr(`PSR_ADDR_REFRESH, 32'h2, r);
    access_is_read_i <= 1'h1;
    fork
      host_u.frame(8);
      probe(50, 2'h2);
    join
    fork
      host_u.frame(8);
      probe(14, 2'h3);
    join
    access_is_read_i <= 1'h0;
    for (int z = 1; z >= 0; z--) begin
      access_zero_lat_i <= z[0];
      fork
        host_u.frame(8);
        probe(50, 2'h0);
      join
    end
  endtask
  task automatic sc_sleep(input logic hw);
    logic [31:0] d;
    logic [1:0]  r;
    int          c;
    wr(`PSR_ADDR_REFRESH, 32'h3, r);
    wr(`PSR_ADDR_PRIMARY, 32'h0, r);
    repeat (ENTRY + 4) @(posedge sys_clk_i);
    chk({31'h0, deep_sleep_state_o}, 32'h1);
    chk({31'h0, array_valid_o}, 32'h0);
    rd(`PSR_ADDR_STATUS, d, r);
    chk(d, 32'h4);
    if (hw) begin
      hw_reset_n_i <= 1'h0;
      repeat (4) @(posedge sys_clk_i);
      hw_reset_n_i <= 1'h1;
    end else begin
      host_u.frame(0);
      repeat (4) @(posedge sys_clk_i);
      rd(`PSR_ADDR_STATUS, d, r);
      chk(d, 32'h8);
    end
    c = 0;
    do begin
      rd(`PSR_ADDR_STATUS, d, r);
      c++;
    end while (d !== 32'h1 && c < 60);
    chk(d, 32'h1);
    rd(`PSR_ADDR_PRIMARY, d, r);
    chk(d, 32'h8000);
    rd(`PSR_ADDR_REFRESH, d, r);
    chk(d, 32'h2);
    chk({31'h0, array_valid_o}, 32'h0);
  endtask
  initial begin
    repeat (3) @(posedge sys_clk_i);
    reset_n_i <= 1'h1;
    repeat (4) @(posedge sys_clk_i);
    sc_reset();
    sc_period();
    sc_link();
    sc_sleep(1'h0);
    sc_sleep(1'h1);
    results();
  end
endmodule // psr_refresh_power_tb
bind psr_refresh_power psr_refresh_power_checker chk_u (.sys_clk_i, .reset_n_i,
  .chip_select_n_i, .strobe_mask_line_o, .strobe_mask_line_oe_o, .data_lines_oe_o,
  .deep_sleep_state_o, .array_valid_o, .refresh_pulse_o);
